//--- bench/mfcs_cfg_asserts.sv
// Checker for the modem configuration space handshakes
`timescale 1ns/100ps
module mfcs_cfg_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cfg_valid,
  input wire logic cfg_ack,
  input wire logic cfg_claim,
  input wire logic mem_ack,
  input wire logic cis_req,
  input wire logic cis_ack,
  input wire logic lan_irq,
  input wire logic modem_irq,
  input wire logic inta_out,
  input wire logic inta_oe_n,
  input wire logic perr_resp_en
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Fetch finishes when the store answers a pending request
  sequence cis_done;
    cis_req && cis_ack;
  endsequence
  // Config answers, fetch and interrupt pin relations
  ack_next_a: assert property (cfg_valid |=> cfg_ack) else $error("no ack");
  ack_cause_a: assert property (cfg_ack |-> $past(cfg_valid)) else $error("stray ack");
  claim_ack_a: assert property (cfg_claim |-> cfg_ack) else $error("stray claim");
  fetch_hold_a: assert property (cis_req && !cis_ack |=> cis_req) else $error("drop");
  fetch_ans_a: assert property (cis_done |=> mem_ack && !cis_req) else $error("no data");
  irq_drive_a: assert property (lan_irq || modem_irq |=> !inta_oe_n) else $error("no irq");
  irq_free_a: assert property (!lan_irq && !modem_irq |=> inta_oe_n) else $error("irq");
  pin_low_a: assert property (!inta_oe_n |-> !inta_out) else $error("pin high");
  perr_keep_a: assert property (!cfg_valid |=> $stable(perr_resp_en)) else $error("en");
endmodule
bind mfcs_config_space mfcs_cfg_asserts u_chk (.clk(clk), .sys_rst(sys_rst),
  .cfg_valid(cfg_valid), .cfg_ack(cfg_ack), .cfg_claim(cfg_claim), .mem_ack(mem_ack),
  .cis_req(cis_req), .cis_ack(cis_ack), .lan_irq(lan_irq), .modem_irq(modem_irq),
  .inta_out(inta_out), .inta_oe_n(inta_oe_n), .perr_resp_en(perr_resp_en));

//--- bench/mfcs_cis_store.sv
// Serial store model answering CIS fetches after a set wait
`timescale 1ns/100ps
module mfcs_cis_store #(
  parameter int WAIT = 2
) (
  input  wire logic       clk,
  input  wire logic       cis_req,
  input  wire logic [9:0] cis_addr,
  output logic            cis_ack,
  output logic [31:0]     cis_data
);
  logic [3:0] cnt_ff = 4'h0;
  initial cis_ack = 1'b0;
  initial cis_data = 32'h0;
  // Answer once per fetch; data lines toggle when not answering
  always @(posedge clk) begin
    cis_ack <= 1'b0;
    cis_data <= ~cis_data;
    if (cis_req && !cis_ack && cnt_ff == WAIT[3:0]) begin
      cis_ack <= 1'b1;
      cis_data <= {16'hC150, 6'h00, cis_addr};
      cnt_ff <= 4'h0;
    end else if (cis_req && !cis_ack) begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

//--- bench/mfcs_config_space_tb_top.sv
// Self-checking bench for the modem configuration space
`timescale 1ns/100ps
module mfcs_config_space_tb_top;
  logic                       clk, sys_rst, cfg_valid, cfg_ack, cfg_claim;
  mfcs_pkg::mfcs_cfg_req_type cfg_req;
  mfcs_pkg::mfcs_evt_type     bus_evt;
  logic [31:0]                cfg_rdata, io_addr, mem_addr, mem_rdata, cis_data, rd;
  logic                       ee_modem_en, cardbus_mode, io_hit, mem_valid, mem_ack;
  logic                       ctl_hit, cis_req, cis_ack, lan_irq, inta_out, inta_oe_n;
  logic                       modem_irq;
  logic [1:0]                 ack_seen;
  logic [33:0]                m_seen;
  logic                       perr_resp_en, serr_resp_en;
  logic [9:0]                 cis_addr;
  int                         error_cnt = 0;
  int                         tests_run = 0;
  int                         cyc = 0;
  // Design and store model; identity values are arbitrary
  mfcs_config_space DUT (.clk(clk), .sys_rst(sys_rst), .cfg_valid(cfg_valid),
    .cfg_req(cfg_req), .cfg_ack(cfg_ack), .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata),
    .ee_modem_en(ee_modem_en), .ee_dev_vendor_id(32'h1357_9BDF), .ee_fe_word(16'h0205),
    .ee_subsys_vendor(16'hA1B2), .ee_subsys_id(16'hC3D4), .cardbus_mode(cardbus_mode),
    .bus_evt(bus_evt), .io_addr(io_addr), .io_hit(io_hit), .mem_valid(mem_valid),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ctl_hit(ctl_hit),
    .cis_req(cis_req), .cis_addr(cis_addr), .cis_ack(cis_ack), .cis_data(cis_data),
    .lan_irq(lan_irq), .modem_irq(modem_irq), .inta_out(inta_out), .inta_oe_n(inta_oe_n),
    .perr_resp_en(perr_resp_en), .serr_resp_en(serr_resp_en));
  mfcs_cis_store u_store (.clk(clk), .cis_req(cis_req), .cis_addr(cis_addr),
    .cis_ack(cis_ack), .cis_data(cis_data));
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cfg(input logic [2:0] fn, input logic [7:0] ofs, input logic we,
                     input logic [3:0] be, input logic [31:0] wd);
    @(posedge clk);
    cfg_valid <= 1'b1;
    cfg_req <= '{fn, ofs, we, be, wd};
    @(posedge clk);
    cfg_valid <= 1'b0;
    @(posedge clk);
    rd = cfg_rdata;
    ack_seen = {cfg_ack, cfg_claim};
  endtask
  task automatic rdc(input logic [7:0] ofs, input logic [31:0] exp);
    cfg(3'h1, ofs, 1'b0, 4'h0, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [3:0] be, input logic [31:0] wd);
    cfg(3'h1, ofs, 1'b1, be, wd);
  endtask
  task automatic rst_pulse(input int n);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (n) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic mem(input logic [31:0] a);
    int n;
    @(posedge clk);
    mem_valid <= 1'b1;
    mem_addr <= a;
    @(posedge clk);
    mem_valid <= 1'b0;
    n = 0;
    m_seen = 34'h0;
    while (m_seen[33] !== 1'b1 && n < 8) begin
      @(posedge clk);
      m_seen = {mem_ack, ctl_hit, mem_rdata};
      n++;
    end
  endtask
  // Fixed values after reset and ignored writes
  task automatic t_fixed();
    rdc(8'h04, 32'h0210_0000);
    rdc(8'h00, 32'h1357_9BDF);
    rdc(8'h08, 32'h0700_0205);
    rdc(8'h0C, 32'h0080_0000);
    rdc(8'h2C, 32'hC3D4_A1B2);
    rdc(8'h34, 32'h0000_00DC);
    wr(8'h08, 4'hF, 32'hFFFF_FFFF);
    wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h08, 32'h0700_0205);
    rdc(8'h0C, 32'h0080_0000);
    wr(8'h04, 4'h3, 32'hFFFF_FFFF);
    rdc(8'h04, 32'h0210_0143);
    chk({30'h0, perr_resp_en, serr_resp_en}, 32'h3);
    cardbus_mode <= 1'b1;
    rdc(8'h28, 32'h0000_0102);
    cardbus_mode <= 1'b0;
    rdc(8'h28, 32'h0);
  endtask
  // Function numbers and the enable from the store
  task automatic t_claim();
    cfg(3'h1, 8'h00, 1'b0, 4'h0, 32'h0);
    chk({ack_seen, rd}, {2'h3, 32'h1357_9BDF});
    cfg(3'h0, 8'h00, 1'b0, 4'h0, 32'h0);
    chk({ack_seen, rd}, {2'h2, 32'h0});
    ee_modem_en <= 1'b0;
    cfg(3'h1, 8'h00, 1'b0, 4'h0, 32'h0);
    chk({ack_seen, rd}, {2'h2, 32'h0});
    ee_modem_en <= 1'b1;
  endtask
  // Sticky events, clear by writing ones, then bus reset
  task automatic t_status();
    @(posedge clk);
    bus_evt <= '{1'b1, 1'b1, 3'h7, 1'b1};
    @(posedge clk);
    bus_evt <= '{1'b0, 1'b0, 3'h0, 1'b0};
    rdc(8'h04, 32'hFB10_0143);
    wr(8'h04, 4'h8, 32'hC000_0000);
    rdc(8'h04, 32'h3B10_0143);
    rst_pulse(2);
    rdc(8'h04, 32'h0210_0000);
  endtask
  // Window sizes, decode and CIS fetch through the memory window
  task automatic t_windows();
    wr(8'h10, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h10, 32'hFFFF_FFF9);
    wr(8'h14, 4'hF, 32'hFFFF_FFFF);
    rdc(8'h14, 32'hFFFF_F000);
    wr(8'h10, 4'hF, 32'h0000_0200);
    wr(8'h14, 4'hF, 32'h0001_0000);
    wr(8'h04, 4'h3, 32'h0000_0003);
    io_addr <= 32'h0000_0204;
    @(posedge clk);
    chk({31'h0, io_hit}, 32'h1);
    io_addr <= 32'h0000_0208;
    @(posedge clk);
    chk({31'h0, io_hit}, 32'h0);
    mem(32'h0001_0010);
    chk(m_seen, {2'h3, 32'h0});
    mem(32'h0001_0104);
    chk({m_seen[33], m_seen[31:0]}, {1'b1, 32'hC150_0001});
    mem(32'h0002_0104);
    chk({31'h0, m_seen[33]}, 32'h0);
  endtask
  // Shared interrupt pin follows the function request
  task automatic t_irq();
    rdc(8'h3C, 32'h0000_0100);
    lan_irq <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk({30'h0, inta_out, inta_oe_n}, 32'h0);
    lan_irq <= 1'b0;
    modem_irq <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    chk({30'h0, inta_out, inta_oe_n}, 32'h0);
    modem_irq <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk({31'h0, inta_oe_n}, 32'h1);
  endtask
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    cfg_valid = 1'b0;
    cfg_req = '{3'h0, 8'h00, 1'b0, 4'h0, 32'h0};
    bus_evt = '{1'b0, 1'b0, 3'h0, 1'b0};
    ee_modem_en = 1'b1;
    cardbus_mode = 1'b0;
    io_addr = 32'h0;
    mem_valid = 1'b0;
    mem_addr = 32'h0;
    lan_irq = 1'b0;
    modem_irq = 1'b0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    t_fixed();
    t_claim();
    t_status();
    t_windows();
    t_irq();
    wrap_up();
  end
endmodule

//--- shared/mfcs_pkg.sv
// Package for the modem function configuration space
// Overview of operation
// - Function zero LAN, function one modem
// - EEPROM setting enables or hides modem function
// - Dword 00h holds EEPROM device/vendor ID
// - Command reserved and fixed bits read zero
// - Command bits 8,6,1,0 writable, reset zero
// - Status flags cleared by bus reset
// - Status fields: errors, aborts, timing 01, cap
// - Class code 07h, 00h, 02h read-only
// - Prog interface and revision from EEPROM FEh
// - Header type reads fixed 80h multifunction
// - I/O BAR requests eight byte window
// - Memory BAR requests 4 KB window
// - CIS pointer fixed 0000_0102h read-only
// - CIS reads fetched from serial EEPROM
// - CIS pointer only in CardBus mode
// - Subsystem vendor ID from EEPROM, read-only
// - Capabilities pointer reads fixed DCh
// - Subsystem ID from EEPROM, read-only
// - Modem and LAN share interrupt A
package mfcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_ID     = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_CLASS  = 8'h08;
  localparam logic [7:0] OFS_HDR    = 8'h0C;
  localparam logic [7:0] OFS_IOBAR  = 8'h10;
  localparam logic [7:0] OFS_MEMBAR = 8'h14;
  localparam logic [7:0] OFS_CIS    = 8'h28;
  localparam logic [7:0] OFS_SUBSYS = 8'h2C;
  localparam logic [7:0] OFS_CAP    = 8'h34;
  localparam logic [7:0] OFS_INTR   = 8'h3C;

  // Fixed values
  localparam logic [2:0]  MODEM_FN   = 3'h1;
  localparam logic [7:0]  BASE_CLASS = 8'h07;
  localparam logic [7:0]  SUB_CLASS  = 8'h00;
  localparam logic [7:0]  HDR_TYPE   = 8'h80;
  localparam logic [31:0] CIS_PTR    = 32'h0000_0102;
  localparam logic [7:0]  CAP_PTR    = 8'hDC;
  localparam logic [7:0]  INT_PIN_A  = 8'h01;
  localparam logic [1:0]  DEVSEL_TIM = 2'h1;
  localparam logic [15:0] CMD_RST    = 16'h0000;
  localparam logic [31:0] BAR_RST    = 32'h0000_0000;

  // Field positions
  localparam int CMD_IO   = 0;
  localparam int CMD_MEM  = 1;
  localparam int CMD_PERR = 6;
  localparam int CMD_SERR = 8;
  localparam int ST_PERR  = 15;
  localparam int ST_SERR  = 14;
  localparam int ST_TABT  = 11;
  localparam int ST_DEVS  = 9;
  localparam int ST_DPD   = 8;
  localparam int ST_CAP   = 4;

  // Window sizes as address bits, CIS start inside memory window
  localparam int          IO_WIN_BITS  = 3;
  localparam int          MEM_WIN_BITS = 12;
  localparam logic [9:0]  CIS_DW_START = 10'h040;
  localparam logic [2:0]  IO_BAR_LOW   = 3'h1;

  // Configuration request
  typedef struct packed {
    logic [2:0]  fn;
    logic [7:0]  ofs;
    logic        we;
    logic [3:0]  be;
    logic [31:0] wdata;
  } mfcs_cfg_req_type;

  // Bus error events from the target interface
  typedef struct packed {
    logic       perr;
    logic       serr;
    logic [2:0] tabt;
    logic       dpd;
  } mfcs_evt_type;

  typedef enum logic [1:0] {
    MFCS_IDLE  = 2'b01,
    MFCS_FETCH = 2'b10
  } mfcs_state_type;

endpackage

//--- verilog/mfcs_config_space.sv
// Modem function configuration space with BAR decode and CIS fetch
`timescale 1ns/100ps
module mfcs_config_space #(
  parameter int CIS_AW = 10
) (
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  input  wire logic                       cfg_valid,
  input  wire mfcs_pkg::mfcs_cfg_req_type cfg_req,
  output logic                            cfg_ack,
  output logic                            cfg_claim,
  output logic [31:0]                     cfg_rdata,
  input  wire logic                       ee_modem_en,
  input  wire logic [31:0]                ee_dev_vendor_id,
  input  wire logic [15:0]                ee_fe_word,
  input  wire logic [15:0]                ee_subsys_vendor,
  input  wire logic [15:0]                ee_subsys_id,
  input  wire logic                       cardbus_mode,
  input  wire mfcs_pkg::mfcs_evt_type     bus_evt,
  input  wire logic [31:0]                io_addr,
  output logic                            io_hit,
  input  wire logic                       mem_valid,
  input  wire logic [31:0]                mem_addr,
  output logic                            mem_ack,
  output logic [31:0]                     mem_rdata,
  output logic                            ctl_hit,
  output logic                            cis_req,
  output logic [CIS_AW-1:0]               cis_addr,
  input  wire logic                       cis_ack,
  input  wire logic [31:0]                cis_data,
  input  wire logic                       lan_irq,
  input  wire logic                       modem_irq,
  output logic                            inta_out,
  output logic                            inta_oe_n,
  output logic                            perr_resp_en,
  output logic                            serr_resp_en
);

  // Refuse CIS index widths the window cannot hold
  // The CIS area needs no more than ten index bits
  if (CIS_AW < 1 || CIS_AW > 10) begin : g_bad_aw
    $error("CIS_AW must lie in 1..10");
  end

  logic [15:0]          cmd_ff;
  logic [15:0]          nxt_cmd;
  logic                 st_perr_ff;
  logic                 st_serr_ff;
  logic [2:0]           st_tabt_ff;
  logic                 st_dpd_ff;
  logic [31:0]          iobar_ff;
  logic [31:0]          nxt_iobar;
  logic [31:0]          membar_ff;
  logic [31:0]          nxt_membar;
  logic                 cfg_ack_ff;
  logic                 cfg_claim_ff;
  logic [31:0]          cfg_rdata_ff;
  logic [31:0]          rd_word;
  logic [15:0]          status_word;
  mfcs_pkg::mfcs_state_type state_ff;
  mfcs_pkg::mfcs_state_type nxt_state;
  logic                 mem_ack_ff;
  logic [31:0]          mem_rdata_ff;
  logic                 ctl_hit_ff;
  logic [CIS_AW-1:0]    cis_addr_ff;
  logic                 inta_oe_n_ff;

  // Unclaimed requests still get an ack so the bus never stalls
  // Claim only function one, and only when EEPROM enables it
  wire claim    = (cfg_req.fn == mfcs_pkg::MODEM_FN) & ee_modem_en;
  wire cfg_wr   = cfg_valid & claim & cfg_req.we;
  wire sel_cmd  = cfg_req.ofs[7:2] == mfcs_pkg::OFS_CMD[7:2];
  wire sel_io   = cfg_req.ofs[7:2] == mfcs_pkg::OFS_IOBAR[7:2];
  wire sel_mem  = cfg_req.ofs[7:2] == mfcs_pkg::OFS_MEMBAR[7:2];
  wire wr_cmd   = cfg_wr & sel_cmd;
  wire wr_io    = cfg_wr & sel_io;
  wire wr_mem   = cfg_wr & sel_mem;

  // Write-one-to-clear strobes for the two writable status bits
  // Only the upper status byte lane can clear them
  wire clr_lane = wr_cmd & cfg_req.be[3];
  wire clr_perr = clr_lane & cfg_req.wdata[16 + mfcs_pkg::ST_PERR];
  wire clr_serr = clr_lane & cfg_req.wdata[16 + mfcs_pkg::ST_SERR];

  // Writable masks; all other bits keep fixed values
  // Low BAR bits answer size probes with the window size
  localparam logic [15:0] CMD_WMASK = 16'h0143;
  localparam logic [31:0] IO_WMASK  = 32'hFFFF_FFF8;
  localparam logic [31:0] MEM_WMASK = 32'hFFFF_F000;

  // Merge written bytes under a writable mask
  // Disabled byte lanes keep their old value
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be,
    input logic [31:0] wmask
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = (new_v[i*8 +: 8] & wmask[i*8 +: 8])
                      | (old_v[i*8 +: 8] & ~wmask[i*8 +: 8]);
      end
    end
    return res;
  endfunction

  // Next values of the writable registers
  // Writes to read-only fields fall away under the masks
  wire [31:0] cmd_merged = merge({16'h0000, cmd_ff}, cfg_req.wdata, cfg_req.be,
                                 {16'h0000, CMD_WMASK});
  assign nxt_cmd    = wr_cmd ? cmd_merged[15:0] : cmd_ff;
  assign nxt_iobar  = wr_io ? merge(iobar_ff, cfg_req.wdata, cfg_req.be, IO_WMASK)
                            : iobar_ff;
  assign nxt_membar = wr_mem ? merge(membar_ff, cfg_req.wdata, cfg_req.be, MEM_WMASK)
                             : membar_ff;

  // Command and BAR storage
  // BARs stay writable while decode is off so sizing works
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cmd_ff    <= mfcs_pkg::CMD_RST;
      iobar_ff  <= mfcs_pkg::BAR_RST;
      membar_ff <= mfcs_pkg::BAR_RST;
    end else begin
      cmd_ff    <= nxt_cmd;
      iobar_ff  <= nxt_iobar;
      membar_ff <= nxt_membar;
    end
  end

  // Sticky status flags; a new event beats a same-cycle clear
  // Abort and parity-detect flags clear only on bus reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_perr_ff <= 1'b0;
      st_serr_ff <= 1'b0;
      st_tabt_ff <= 3'h0;
      st_dpd_ff  <= 1'b0;
    end else begin
      st_perr_ff <= bus_evt.perr | (st_perr_ff & ~clr_perr);
      st_serr_ff <= bus_evt.serr | (st_serr_ff & ~clr_serr);
      st_tabt_ff <= bus_evt.tabt | st_tabt_ff;
      st_dpd_ff  <= bus_evt.dpd | st_dpd_ff;
    end
  end

  // Status word assembly, fixed fields included
  // Timing field and capability bit are constants
  always_comb begin
    status_word = 16'h0000;
    status_word[mfcs_pkg::ST_PERR]      = st_perr_ff;
    status_word[mfcs_pkg::ST_SERR]      = st_serr_ff;
    status_word[mfcs_pkg::ST_TABT +: 3] = st_tabt_ff;
    status_word[mfcs_pkg::ST_DEVS +: 2] = mfcs_pkg::DEVSEL_TIM;
    status_word[mfcs_pkg::ST_DPD]       = st_dpd_ff;
    status_word[mfcs_pkg::ST_CAP]       = 1'b1;
  end

  // Read data selection by dword offset
  // Offsets with nothing behind them read zero
  always_comb begin
    case (cfg_req.ofs[7:2])
      mfcs_pkg::OFS_ID[7:2]: begin
        rd_word = ee_dev_vendor_id;
      end
      mfcs_pkg::OFS_CMD[7:2]: begin
        rd_word = {status_word, cmd_ff & CMD_WMASK};
      end
      mfcs_pkg::OFS_CLASS[7:2]: begin
        rd_word = {mfcs_pkg::BASE_CLASS, mfcs_pkg::SUB_CLASS, ee_fe_word};
      end
      mfcs_pkg::OFS_HDR[7:2]: begin
        rd_word = {8'h00, mfcs_pkg::HDR_TYPE, 16'h0000};
      end
      mfcs_pkg::OFS_IOBAR[7:2]: begin
        rd_word = {iobar_ff[31:3], mfcs_pkg::IO_BAR_LOW};
      end
      mfcs_pkg::OFS_MEMBAR[7:2]: begin
        rd_word = membar_ff;
      end
      mfcs_pkg::OFS_CIS[7:2]: begin
        rd_word = cardbus_mode ? mfcs_pkg::CIS_PTR : 32'h0000_0000;
      end
      mfcs_pkg::OFS_SUBSYS[7:2]: begin
        rd_word = {ee_subsys_id, ee_subsys_vendor};
      end
      mfcs_pkg::OFS_CAP[7:2]: begin
        rd_word = {24'h00_0000, mfcs_pkg::CAP_PTR};
      end
      mfcs_pkg::OFS_INTR[7:2]: begin
        rd_word = {16'h0000, mfcs_pkg::INT_PIN_A, 8'h00};
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Configuration answer one cycle after the request
  // Writes and foreign requests return zero data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_ack_ff   <= 1'b0;
      cfg_claim_ff <= 1'b0;
      cfg_rdata_ff <= 32'h0000_0000;
    end else begin
      cfg_ack_ff   <= cfg_valid;
      cfg_claim_ff <= cfg_valid & claim;
      cfg_rdata_ff <= (cfg_valid & claim & ~cfg_req.we) ? rd_word : 32'h0000_0000;
    end
  end

  assign cfg_ack      = cfg_ack_ff;
  assign cfg_claim    = cfg_claim_ff;
  assign cfg_rdata    = cfg_rdata_ff;
  assign perr_resp_en = cmd_ff[mfcs_pkg::CMD_PERR];
  assign serr_resp_en = cmd_ff[mfcs_pkg::CMD_SERR];

  // I/O window decode, live only once software enables it
  // Address bits inside the window take no part in the compare
  wire io_match = io_addr[31:mfcs_pkg::IO_WIN_BITS] == iobar_ff[31:mfcs_pkg::IO_WIN_BITS];
  assign io_hit = ee_modem_en & cmd_ff[mfcs_pkg::CMD_IO] & io_match;

  // Memory window decode and split into control and CIS areas
  // A request during a fetch is dropped; one access at a time
  wire mem_match = mem_addr[31:mfcs_pkg::MEM_WIN_BITS]
                == membar_ff[31:mfcs_pkg::MEM_WIN_BITS];
  wire mem_hit   = ee_modem_en & cmd_ff[mfcs_pkg::CMD_MEM] & mem_match;
  wire [9:0] mem_dw  = mem_addr[11:2];
  wire       cis_hit = mem_dw >= mfcs_pkg::CIS_DW_START;
  wire [9:0] cis_dw  = mem_dw - mfcs_pkg::CIS_DW_START;
  wire       mem_go  = (state_ff == mfcs_pkg::MFCS_IDLE) & mem_valid & mem_hit;

  // CIS fetch sequencing
  always_comb begin
    case (state_ff)
      mfcs_pkg::MFCS_IDLE: begin
        if (mem_go & cis_hit) begin
          nxt_state = mfcs_pkg::MFCS_FETCH;
        end else begin
          nxt_state = mfcs_pkg::MFCS_IDLE;
        end
      end
      mfcs_pkg::MFCS_FETCH: begin
        if (cis_ack) begin
          nxt_state = mfcs_pkg::MFCS_IDLE;
        end else begin
          nxt_state = mfcs_pkg::MFCS_FETCH;
        end
      end
      default: begin
        nxt_state = mfcs_pkg::MFCS_IDLE;
      end
    endcase
  end

  // Fetch ends on the store's answer; control hits answer on the next cycle
  wire fetch_busy = state_ff == mfcs_pkg::MFCS_FETCH;
  wire fetch_done = fetch_busy & cis_ack;
  wire ctl_go     = mem_go & ~cis_hit;

  // Memory answer: CIS data from EEPROM, control area reads zero here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff     <= mfcs_pkg::MFCS_IDLE;
      mem_ack_ff   <= 1'b0;
      mem_rdata_ff <= 32'h0000_0000;
      ctl_hit_ff   <= 1'b0;
      cis_addr_ff  <= '0;
    end else begin
      state_ff     <= nxt_state;
      mem_ack_ff   <= fetch_done | ctl_go;
      mem_rdata_ff <= fetch_done ? cis_data : 32'h0000_0000;
      ctl_hit_ff   <= ctl_go;
      if (mem_go & cis_hit) begin
        cis_addr_ff <= cis_dw[CIS_AW-1:0];
      end
    end
  end

  assign mem_ack   = mem_ack_ff;
  assign mem_rdata = mem_rdata_ff;
  assign ctl_hit   = ctl_hit_ff;
  assign cis_req   = fetch_busy;
  assign cis_addr  = cis_addr_ff;

  // Shared interrupt A, open drain: drive low while either function asks
  // Registered so request glitches never reach the shared pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      inta_oe_n_ff <= 1'b1;
    end else begin
      inta_oe_n_ff <= ~(lan_irq | modem_irq);
    end
  end

  assign inta_out  = 1'b0;
  assign inta_oe_n = inta_oe_n_ff;

endmodule
